// ==== rtl/cfg_five_pkg.sv ====
// Constants, field positions and carrier types for the fifth configuration register.
// Assumes one core clock domain; all callers import the whole package.
// Summary of operation
// - Checksum presence flag bit 18, preset, read-only
// - Map-ID zero: map identifier writes ignored, reads zero
// - Map-ID one: space identifier writes ignored, reads zero
// - Map-ID select writable only when invalidate is 11
// - Global invalidate field bits 16:15, preset encoding
// - Compact v2 flag forces compact presence one
// - Paired atomic absent flag bit 13, read-only
// - Dual endian flag; endian change applies at reset
// - Secondary config absent flag bit 10, preset
// - User emulation access gates user emulation moves
// - Emulation enable traps single-precision and word moves
// - Register mode zero forces effective emulation off
// - Virtual processor flag bit 7, same everywhere
// - Breakpoint restrict traps non-kernel debug breakpoint
// - High-half move flag bit 5, preset
// - Memory attribute register flag bit 3, preset
// - User FR access writable only with FPU support
package cfg_five_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned EXT_ADDR_BIT = 19;
   localparam int unsigned CHECKSUM_BIT = 18;
   localparam int unsigned MAPSEL_BIT = 17;
   localparam int unsigned INVAL_LO = 15;
   localparam int unsigned COMPACT_V2_BIT = 14;
   localparam int unsigned PAIR_ABSENT_BIT = 13;
   localparam int unsigned RSV_BIT = 12;
   localparam int unsigned ENDIAN_BIT = 11;
   localparam int unsigned CFG2_ABSENT_BIT = 10;
   localparam int unsigned USER_EMUL_BIT = 9;
   localparam int unsigned EMUL_EN_BIT = 8;
   localparam int unsigned VIRT_PROC_BIT = 7;
   localparam int unsigned BREAK_LIMIT_BIT = 6;
   localparam int unsigned HIGH_MOVE_BIT = 5;
   localparam int unsigned LINK_BIT = 4;
   localparam int unsigned MEM_ATTR_BIT = 3;
   localparam int unsigned USER_FR_BIT = 2;
   localparam logic [1:0] INVAL_BOTH = 2'h3;
   localparam logic CTRL_RESET = 1'h0;
   localparam logic LINK_VALUE = 1'h1;
   localparam logic [1:0] MODE_USER = 2'h2;
   localparam logic [1:0] MODE_SUPER = 2'h1;
   localparam logic [1:0] MODE_KERNEL = 2'h0;

   typedef struct packed {
      logic extended_phys_addr_present;
      logic checksum_insn_present;
      logic [1:0] global_invalidate_support;
      logic compact_isa_v2_flag;
      logic paired_atomic_absent;
      logic dual_endian_capable;
      logic secondary_cache_cfg_absent;
      logic virtual_processor_flag;
      logic high_half_move_flag;
      logic mem_attr_reg_present;
      logic fpu_user_fr_support;
   } preset_t;

   typedef struct packed {
      logic map_id_select;
      logic user_fp_emul_access;
      logic fp_emulation_enable;
      logic debug_break_restrict;
      logic user_fr_access;
   } ctrl_t;

   typedef struct packed {
      logic single_arith;
      logic word_load_or_mtc;
      logic word_store_or_mfc;
      logic fp_branch;
      logic debug_break;
      logic user_emul_move;
      logic [1:0] mode;
   } insn_t;

   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [DATA_W-1:0] wr_data;
   } cp_req_t;
endpackage

// ==== rtl/cfg_five_trap.sv ====
// Decodes which instructions must take a reserved-instruction trap.
// Assumes the instruction class and privilege mode come from the decode stage, same clock.
module cfg_five_trap
   import cfg_five_pkg::*;
(
   // Decode view
   input wire insn_t insn,
   // Live controls
   input wire ctrl_t ctrl,
   input wire logic fp_register_mode_bit,
   // Result
   output logic trap,
   output logic emul_effective
);
   always_comb begin
      // Stored enable is masked by register mode, never cleared
      emul_effective = ctrl.fp_emulation_enable & fp_register_mode_bit;
      trap = 1'b0;
      if (emul_effective && (insn.single_arith || insn.word_load_or_mtc ||
          insn.word_store_or_mfc)) begin
         trap = 1'b1;
      end
      if (insn.debug_break && ctrl.debug_break_restrict && insn.mode != MODE_KERNEL) begin
         trap = 1'b1;
      end
      if (insn.user_emul_move && insn.mode == MODE_USER && !ctrl.user_fp_emul_access) begin
         trap = 1'b1;
      end
   end
endmodule

// ==== rtl/cfg_five_ident.sv ====
// Identifier gating between map identifier and address space identifiers.
// Assumes write strobes and read data from the owning registers arrive on the same clock.
module cfg_five_ident
   import cfg_five_pkg::*;
(
   // Selection
   input wire logic map_id_select,
   // Raw strobes
   input wire logic map_wr,
   input wire logic space_wr,
   // Raw read data
   input wire logic [DATA_W-1:0] map_rd_raw,
   input wire logic [DATA_W-1:0] space_rd_raw,
   // Gated results
   output logic map_wr_ok,
   output logic space_wr_ok,
   output logic [DATA_W-1:0] map_rd,
   output logic [DATA_W-1:0] space_rd
);
   always_comb begin
      map_wr_ok = map_wr & map_id_select;
      map_rd = map_id_select ? map_rd_raw : '0;
      space_wr_ok = space_wr & ~map_id_select;
      space_rd = map_id_select ? '0 : space_rd_raw;
   end
endmodule

// ==== rtl/cfg_five.sv ====
// Fifth configuration register, bits 19:2, reached by privileged coprocessor moves.
// Assumes presets are tied constants and moves are pre-qualified as privileged.
module cfg_five
   import cfg_five_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Coprocessor move port
   input wire cp_req_t cp_req,
   output logic [DATA_W-1:0] cp_rd_data,
   // Hardware presets
   input wire preset_t preset,
   // Register mode status and decode
   input wire logic fp_register_mode_bit,
   input wire insn_t insn,
   // User emulation move writes only the emulation enable
   input wire logic user_emul_wr,
   input wire logic user_emul_wdata,
   // Identifier gating
   input wire logic map_wr,
   input wire logic space_wr,
   input wire logic [DATA_W-1:0] map_rd_raw,
   input wire logic [DATA_W-1:0] space_rd_raw,
   output logic map_wr_ok,
   output logic space_wr_ok,
   output logic [DATA_W-1:0] map_rd,
   output logic [DATA_W-1:0] space_rd,
   // Status outputs
   output logic compact_isa_present,
   output logic boot_little_endian,
   output logic reserved_insn_trap,
   output logic emul_effective
);
   typedef struct packed {
      ctrl_t ctrl;
      logic [DATA_W-1:0] rd;
      logic trap;
      logic emul;
      logic map_wr_ok;
      logic space_wr_ok;
      logic [DATA_W-1:0] map_rd;
      logic [DATA_W-1:0] space_rd;
      logic ca;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic trap_c;
   logic emul_c;
   logic mwo_c;
   logic swo_c;
   logic [DATA_W-1:0] mrd_c;
   logic [DATA_W-1:0] srd_c;
   logic [DATA_W-1:0] view;

   default clocking dflt_cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   cfg_five_trap u_trap (
      .insn(insn),
      .ctrl(st_r.ctrl),
      .fp_register_mode_bit(fp_register_mode_bit),
      .trap(trap_c),
      .emul_effective(emul_c)
   );

   cfg_five_ident u_ident (
      .map_id_select(st_r.ctrl.map_id_select),
      .map_wr(map_wr),
      .space_wr(space_wr),
      .map_rd_raw(map_rd_raw),
      .space_rd_raw(space_rd_raw),
      .map_wr_ok(mwo_c),
      .space_wr_ok(swo_c),
      .map_rd(mrd_c),
      .space_rd(srd_c)
   );

   always_comb begin
      // Presets come straight from straps; bit 12 and unlisted bits stay zero
      view = '0;
      view[EXT_ADDR_BIT] = preset.extended_phys_addr_present;
      view[CHECKSUM_BIT] = preset.checksum_insn_present;
      view[MAPSEL_BIT] = st_r.ctrl.map_id_select;
      view[INVAL_LO +: 2] = preset.global_invalidate_support;
      view[COMPACT_V2_BIT] = preset.compact_isa_v2_flag;
      view[PAIR_ABSENT_BIT] = preset.paired_atomic_absent;
      view[ENDIAN_BIT] = preset.dual_endian_capable;
      view[CFG2_ABSENT_BIT] = preset.secondary_cache_cfg_absent;
      view[USER_EMUL_BIT] = st_r.ctrl.user_fp_emul_access;
      view[EMUL_EN_BIT] = st_r.ctrl.fp_emulation_enable;
      view[VIRT_PROC_BIT] = preset.virtual_processor_flag;
      view[BREAK_LIMIT_BIT] = st_r.ctrl.debug_break_restrict;
      view[HIGH_MOVE_BIT] = preset.high_half_move_flag;
      view[LINK_BIT] = LINK_VALUE;
      view[MEM_ATTR_BIT] = preset.mem_attr_reg_present;
      view[USER_FR_BIT] = st_r.ctrl.user_fr_access;
   end

   always_comb begin
      st_nxt = st_r;
      if (cp_req.wr_en) begin
         // Only control bits take write data; presets ignore it
         if (preset.global_invalidate_support == INVAL_BOTH) begin
            st_nxt.ctrl.map_id_select = cp_req.wr_data[MAPSEL_BIT];
         end
         st_nxt.ctrl.user_fp_emul_access = cp_req.wr_data[USER_EMUL_BIT];
         st_nxt.ctrl.fp_emulation_enable = cp_req.wr_data[EMUL_EN_BIT];
         st_nxt.ctrl.debug_break_restrict = cp_req.wr_data[BREAK_LIMIT_BIT];
         st_nxt.ctrl.user_fr_access = cp_req.wr_data[USER_FR_BIT] &
            preset.fpu_user_fr_support;
      end else if (user_emul_wr && st_r.ctrl.user_fp_emul_access) begin
         st_nxt.ctrl.fp_emulation_enable = user_emul_wdata;
      end
      // Straps may move after reset; keep the forced zeros honest
      if (preset.global_invalidate_support != INVAL_BOTH) begin
         st_nxt.ctrl.map_id_select = 1'b0;
      end
      if (!preset.fpu_user_fr_support) begin
         st_nxt.ctrl.user_fr_access = 1'b0;
      end
      st_nxt.rd = cp_req.rd_en ? view : '0;
      st_nxt.trap = trap_c;
      st_nxt.emul = emul_c;
      st_nxt.map_wr_ok = mwo_c;
      st_nxt.space_wr_ok = swo_c;
      st_nxt.map_rd = mrd_c;
      st_nxt.space_rd = srd_c;
      st_nxt.ca = preset.compact_isa_v2_flag;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Endian choice from an external register only lands at reset; boot is always little
   assign boot_little_endian = 1'b1;
   assign cp_rd_data = st_r.rd;
   assign reserved_insn_trap = st_r.trap;
   assign emul_effective = st_r.emul;
   assign map_wr_ok = st_r.map_wr_ok;
   assign space_wr_ok = st_r.space_wr_ok;
   assign map_rd = st_r.map_rd;
   assign space_rd = st_r.space_rd;
   assign compact_isa_present = st_r.ca;

   a_mapsel_gate: assert property (
      preset.global_invalidate_support != INVAL_BOTH
      |=> !st_r.ctrl.map_id_select)
      else $error("map select set without full invalidate");

   a_map_write_gate: assert property (
      map_wr && !st_r.ctrl.map_id_select
      |=> !map_wr_ok)
      else $error("map identifier write passed while deselected");

   a_space_write_gate: assert property (
      space_wr && st_r.ctrl.map_id_select
      |=> !space_wr_ok)
      else $error("space identifier write passed while map selected");

   a_reserved_zero: assert property (
      $past(cp_req.rd_en)
      |-> cp_rd_data[RSV_BIT] == 1'b0 && cp_rd_data[LINK_BIT])
      else $error("reserved or link bit wrong");

   a_emul_mask: assert property (
      !fp_register_mode_bit
      |=> !emul_effective)
      else $error("emulation effective with register mode zero");

   a_emul_trap: assert property (
      st_r.ctrl.fp_emulation_enable && fp_register_mode_bit && insn.single_arith
      |=> reserved_insn_trap)
      else $error("single arith not trapped");

   a_break_trap: assert property (
      insn.debug_break && st_r.ctrl.debug_break_restrict && insn.mode == MODE_USER
      |=> reserved_insn_trap)
      else $error("user breakpoint not trapped");

   a_ufr_gate: assert property (
      !preset.fpu_user_fr_support
      |=> !st_r.ctrl.user_fr_access)
      else $error("user fr access set without support");

   a_ca_follow: assert property (
      preset.compact_isa_v2_flag
      |=> compact_isa_present)
      else $error("compact presence not forced");

   a_crc_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[CHECKSUM_BIT] == $past(preset.checksum_insn_present))
      else $error("checksum flag misread");

   a_pair_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[PAIR_ABSENT_BIT] == $past(preset.paired_atomic_absent))
      else $error("paired atomic flag misread");

   a_inval_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[INVAL_LO +: 2] == $past(preset.global_invalidate_support))
      else $error("invalidate field misread");

   a_endian_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[ENDIAN_BIT] == $past(preset.dual_endian_capable))
      else $error("endian flag misread");

   a_cfg2_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[CFG2_ABSENT_BIT] == $past(preset.secondary_cache_cfg_absent))
      else $error("second config flag misread");

   a_virt_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[VIRT_PROC_BIT] == $past(preset.virtual_processor_flag))
      else $error("virtual processor flag misread");

   a_high_move_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[HIGH_MOVE_BIT] == $past(preset.high_half_move_flag))
      else $error("high half move flag misread");

   a_mem_attr_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[MEM_ATTR_BIT] == $past(preset.mem_attr_reg_present))
      else $error("memory attribute flag misread");

   a_v2_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[COMPACT_V2_BIT] == $past(preset.compact_isa_v2_flag))
      else $error("compact v2 flag misread");

   a_link_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[LINK_BIT] == LINK_VALUE)
      else $error("link bit flag not one");

   a_upper_zero: assert property (
      cp_req.rd_en
      |=> cp_rd_data[DATA_W-1:EXT_ADDR_BIT+1] == '0)
      else $error("upper bits not zero");

   a_low_zero: assert property (
      cp_req.rd_en
      |=> cp_rd_data[1:0] == 2'h0)
      else $error("low bits not zero");

   a_map_sel_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[MAPSEL_BIT] == $past(st_r.ctrl.map_id_select))
      else $error("map select misread");

   a_ufe_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[USER_EMUL_BIT] == $past(st_r.ctrl.user_fp_emul_access))
      else $error("user emulation access misread");

   a_fre_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[EMUL_EN_BIT] == $past(st_r.ctrl.fp_emulation_enable))
      else $error("emulation enable misread");

   a_break_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[BREAK_LIMIT_BIT] == $past(st_r.ctrl.debug_break_restrict))
      else $error("breakpoint restrict misread");

   a_ufr_read: assert property (
      cp_req.rd_en
      |=> cp_rd_data[USER_FR_BIT] == $past(st_r.ctrl.user_fr_access))
      else $error("user fr access misread");

   a_map_read_gate: assert property (
      !st_r.ctrl.map_id_select
      |=> map_rd == '0)
      else $error("map identifier read while deselected");

   a_space_read_gate: assert property (
      st_r.ctrl.map_id_select
      |=> space_rd == '0)
      else $error("space identifier read while map selected");

   a_map_write_pass: assert property (
      map_wr && st_r.ctrl.map_id_select
      |=> map_wr_ok)
      else $error("map identifier write lost while selected");

   a_space_write_pass: assert property (
      space_wr && !st_r.ctrl.map_id_select
      |=> space_wr_ok)
      else $error("space identifier write lost while deselected");

   a_load_trap: assert property (
      st_r.ctrl.fp_emulation_enable && fp_register_mode_bit && insn.word_load_or_mtc
      |=> reserved_insn_trap)
      else $error("word load not trapped");

   a_store_trap: assert property (
      st_r.ctrl.fp_emulation_enable && fp_register_mode_bit && insn.word_store_or_mfc
      |=> reserved_insn_trap)
      else $error("word store not trapped");

   a_branch_free: assert property (
      insn == '{fp_branch: 1'b1, mode: insn.mode, default: 1'b0}
      |=> !reserved_insn_trap)
      else $error("fp branch trapped");

   a_super_break: assert property (
      insn.debug_break && st_r.ctrl.debug_break_restrict && insn.mode == MODE_SUPER
      |=> reserved_insn_trap)
      else $error("supervisor breakpoint not trapped");

   a_user_move_trap: assert property (
      insn.user_emul_move && insn.mode == MODE_USER && !st_r.ctrl.user_fp_emul_access
      |=> reserved_insn_trap)
      else $error("user emulation move not trapped");

   a_user_move_write: assert property (
      user_emul_wr && st_r.ctrl.user_fp_emul_access && !cp_req.wr_en
      |=> st_r.ctrl.fp_emulation_enable == $past(user_emul_wdata))
      else $error("user emulation move lost");

   a_user_move_block: assert property (
      user_emul_wr && !st_r.ctrl.user_fp_emul_access && !cp_req.wr_en
      |=> $stable(st_r.ctrl.fp_emulation_enable))
      else $error("user emulation move passed without access");

   a_emul_follow: assert property (
      fp_register_mode_bit && st_r.ctrl.fp_emulation_enable
      |=> emul_effective)
      else $error("emulation not effective");

   a_ufr_write: assert property (
      cp_req.wr_en && preset.fpu_user_fr_support
      |=> st_r.ctrl.user_fr_access == $past(cp_req.wr_data[USER_FR_BIT]))
      else $error("user fr access write lost");

   a_mapsel_write: assert property (
      cp_req.wr_en && preset.global_invalidate_support == INVAL_BOTH
      |=> st_r.ctrl.map_id_select == $past(cp_req.wr_data[MAPSEL_BIT]))
      else $error("map select write lost");

   c_mapsel_set: cover property (
      $rose(st_r.ctrl.map_id_select));
   c_emul_trap: cover property (
      reserved_insn_trap && emul_effective);
   c_user_move: cover property (
      user_emul_wr && st_r.ctrl.user_fp_emul_access);
   c_break_trap: cover property (
      reserved_insn_trap && !emul_effective);
   c_space_pass: cover property (
      space_wr_ok && !st_r.ctrl.map_id_select);
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the fifth configuration register block.
// Assumes presets are static levels, changed only while reset is held.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end
module tb_top
   import cfg_five_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'h0;
   logic rst_b = 1'h0;
   cp_req_t cp_req = '0;
   preset_t preset = 12'hBAB;
   logic fp_register_mode_bit = 1'h1;
   insn_t insn = '0;
   logic user_emul_wr = 1'h0;
   logic user_emul_wdata = 1'h0;
   logic map_wr = 1'h0;
   logic space_wr = 1'h0;
   logic [DATA_W-1:0] map_rd_raw = '0;
   logic [DATA_W-1:0] space_rd_raw = '0;
   logic map_wr_ok, space_wr_ok, compact_isa_present, boot_little_endian;
   logic reserved_insn_trap, emul_effective;
   logic [DATA_W-1:0] cp_rd_data, map_rd, space_rd, v;
   ctrl_t m;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   logic t;

   cfg_five cfg_five_i (.core_clk(core_clk), .rst_b(rst_b), .cp_req(cp_req),
      .cp_rd_data(cp_rd_data), .preset(preset), .fp_register_mode_bit(fp_register_mode_bit),
      .insn(insn), .user_emul_wr(user_emul_wr), .user_emul_wdata(user_emul_wdata),
      .map_wr(map_wr), .space_wr(space_wr), .map_rd_raw(map_rd_raw),
      .space_rd_raw(space_rd_raw), .map_wr_ok(map_wr_ok), .space_wr_ok(space_wr_ok),
      .map_rd(map_rd), .space_rd(space_rd), .compact_isa_present(compact_isa_present),
      .boot_little_endian(boot_little_endian), .reserved_insn_trap(reserved_insn_trap),
      .emul_effective(emul_effective));

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         end_sim();
      end
   end

   function automatic logic [DATA_W-1:0] exp_rd();
      logic [DATA_W-1:0] e;
      e = '0;
      e[EXT_ADDR_BIT:USER_FR_BIT] = {preset.extended_phys_addr_present,
         preset.checksum_insn_present,
         m.map_id_select, preset.global_invalidate_support, preset.compact_isa_v2_flag,
         preset.paired_atomic_absent, 1'h0, preset.dual_endian_capable,
         preset.secondary_cache_cfg_absent, m.user_fp_emul_access, m.fp_emulation_enable,
         preset.virtual_processor_flag, m.debug_break_restrict, preset.high_half_move_flag,
         1'h1, preset.mem_attr_reg_present, m.user_fr_access};
      return e;
   endfunction

   task automatic do_reset(input preset_t p);
      rst_b <= 1'h0;
      preset <= p;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'h1;
      m = '0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      cp_req <= '{wr_en: 1'h1, rd_en: 1'h0, wr_data: d};
      @(posedge core_clk);
      cp_req <= '0;
      // Map select only sticks when both global invalidates exist
      m.map_id_select = (preset.global_invalidate_support == INVAL_BOTH) & d[MAPSEL_BIT];
      m.user_fp_emul_access = d[USER_EMUL_BIT];
      m.fp_emulation_enable = d[EMUL_EN_BIT];
      m.debug_break_restrict = d[BREAK_LIMIT_BIT];
      m.user_fr_access = preset.fpu_user_fr_support & d[USER_FR_BIT];
   endtask

   task automatic rd(output logic [DATA_W-1:0] r);
      @(posedge core_clk);
      cp_req <= '{wr_en: 1'h0, rd_en: 1'h1, wr_data: 32'h0};
      @(posedge core_clk);
      cp_req <= '0;
      #1 r = cp_rd_data;
   endtask

   task automatic trap_chk(input insn_t i, output logic r);
      @(posedge core_clk);
      insn <= i;
      @(posedge core_clk);
      #1 r = reserved_insn_trap;
   endtask

   task automatic uemul(input logic d);
      @(posedge core_clk);
      user_emul_wr <= 1'h1;
      user_emul_wdata <= d;
      @(posedge core_clk);
      user_emul_wr <= 1'h0;
      if (m.user_fp_emul_access) m.fp_emulation_enable = d;
   endtask

   task automatic t_presets();
      do_reset(12'hBAB);
      rd(v);
      `CHK(v, exp_rd())
      @(posedge core_clk);
      #1 `CHK(cp_rd_data, 32'h0)
      `CHK(compact_isa_present, 1'h1)
      `CHK(boot_little_endian, 1'h1)
      $display("test presets done");
   endtask

   task automatic t_write();
      wr(32'hFFFFFFFF);
      rd(v);
      `CHK(v, exp_rd())
      wr(32'h0);
      rd(v);
      `CHK(v, exp_rd())
      $display("test write done");
   endtask

   task automatic t_ident();
      for (int i = 0; i < 2; i++) begin
         // Identifiers are undefined after a select change, so raw data is driven afresh
         wr(i ? 32'h00020000 : 32'h0);
         @(posedge core_clk);
         map_wr <= 1'h1;
         space_wr <= 1'h1;
         map_rd_raw <= 32'hA5A50001;
         space_rd_raw <= 32'h5A5A0002;
         @(posedge core_clk);
         map_wr <= 1'h0;
         space_wr <= 1'h0;
         #1 `CHK(map_wr_ok, i[0])
         `CHK(map_rd, i ? 32'hA5A50001 : 32'h0)
         `CHK(space_wr_ok, ~i[0])
         `CHK(space_rd, i ? 32'h0 : 32'h5A5A0002)
      end
      $display("test identifier done");
   endtask

   task automatic t_trap();
      insn_t tbl[7] = '{8'h82, 8'h42, 8'h22, 8'h12, 8'h0A, 8'h09, 8'h08};
      logic texp[7] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
      wr(32'h00000140);
      for (int i = 0; i < 7; i++) begin
         trap_chk(tbl[i], t);
         `CHK(t, texp[i])
      end
      @(posedge core_clk);
      fp_register_mode_bit <= 1'h0;
      trap_chk(8'h82, t);
      `CHK(t, 1'h0)
      `CHK(emul_effective, 1'h0)
      @(posedge core_clk);
      fp_register_mode_bit <= 1'h1;
      trap_chk(8'h82, t);
      `CHK(emul_effective, 1'h1)
      $display("test trap done");
   endtask

   task automatic t_user();
      wr(32'h0);
      trap_chk(8'h06, t);
      `CHK(t, 1'h1)
      uemul(1'h1);
      rd(v);
      `CHK(v, exp_rd())
      wr(32'h00000200);
      trap_chk(8'h06, t);
      `CHK(t, 1'h0)
      uemul(1'h1);
      rd(v);
      `CHK(v, exp_rd())
      $display("test user access done");
   endtask

   task automatic t_gi_low();
      do_reset(12'h654);
      wr(32'hFFFFFFFF);
      rd(v);
      `CHK(v, exp_rd())
      `CHK(compact_isa_present, 1'h0)
      $display("test partial invalidate done");
   endtask

   initial begin
      t_presets();
      t_write();
      t_ident();
      t_trap();
      t_user();
      t_gi_low();
      end_sim();
   end
endmodule
